// ==== verilog/processor_port_transaction_logic.sv ====
// Request issue and reply logic of a processor port on a coherent interconnect
// Function
// - Cache miss reads and block loads go out in ordering class 0.
// - Writes, interrupts and noncached accesses use class 1.
// - Every outgoing request carries a four-bit transaction type field.
// - Data load miss issues read-to-share.
// - Instruction fetch miss issues read-to-share-always.
// - Store miss, store hit shared, merge read issue read-to-own.
// - Block load issues read-to-discard, data not cached.
// - Dirty victim issues writeback, tied to earlier read of same location.
// - Block store issues write-and-invalidate.
// - Noncacheable load issues noncached single read of 1 to 16 bytes.
// - Noncacheable block access issues 64-byte noncached block read or write.
// - Copyback-to-discard keeps line state and skips store buffer flush.
// - Slave read returns port identifier with read-single-ready reply.
// - Replies drive five output pins, idle code when nothing to say.
// - Non-existent block reply only on miss without duplicate tags.
// - Snoop hit replies dirty-victim ack if pending writeback, else coherent ack.
// - Interrupt acknowledge once a delivered interrupt has been serviced.
// - Noncached block read aimed here gets read-error reply, no data.
// - Address bus or tag parity error sends fatal-error reply.
// - Reply codes fixed; idle and fatal one cycle, others two cycles.
// - Reply class copied from request for two-cycle replies, zero for idle.
`timescale 1ns/10ps
`default_nettype none

module processor_port_transaction_logic (
	input  wire logic                               clock_i,
	input  wire logic                               rst_i,
	// Core and cache side requests
	input  wire logic                               core_req_valid_i,
	input  wire port_pkg::core_req_s                core_req_i,
	output logic                                    core_req_ready_o,
	// Outgoing requests on the system address bus
	output logic                                    addr_req_valid_o,
	output var port_pkg::addr_req_s                 addr_req_o,
	input  wire logic                               addr_grant_i,
	// Incoming system requests
	input  wire logic                               sys_req_valid_i,
	input  wire port_pkg::sys_req_s                 sys_req_i,
	output logic                                    sys_req_ready_o,
	// External cache tag lookup
	output logic                                    lookup_valid_o,
	output var port_pkg::lookup_req_s               lookup_o,
	input  wire logic                               lookup_done_i,
	input  wire port_pkg::lookup_res_s              lookup_result_i,
	// Interrupt delivery
	output logic                                    int_delivered_o,
	input  wire logic                               int_serviced_i,
	// Slave read data toward the data buffer
	output logic [port_pkg::DATA_W-1:0]             slave_data_o,
	output logic                                    slave_data_valid_o,
	// Pins and error sources
	input  wire logic [port_pkg::PORT_ID_W-1:0]     port_id_i,
	input  wire logic                               duplicate_tags_i,
	input  wire logic                               addr_parity_err_i,
	input  wire logic                               tag_parity_err_i,
	// Reply pins
	output logic [4:0]                              p_reply_o
);

	typedef enum logic [1:0] {
		SNOOP_IDLE,
		SNOOP_LOOKUP,
		SNOOP_REPLY
	} snoop_state_e;

	snoop_state_e                       snoop_state_reg;
	port_pkg::addr_req_s                addr_req_reg;
	logic                               addr_req_valid_reg;
	port_pkg::sys_req_s                 sys_req_reg;
	logic [3:0]                         snoop_code_reg;
	logic [port_pkg::DATA_W-1:0]        slave_data_reg;
	logic                               slave_data_valid_reg;
	logic                               int_pending_reg;
	logic                               int_cls_reg;
	logic                               int_ack_pending_reg;
	logic                               fatal_pending_reg;
	logic [port_pkg::PORT_ID_W-1:0]     port_id_meta_reg;
	logic [port_pkg::PORT_ID_W-1:0]     port_id_reg;
	logic                               duplicate_tags_meta_reg;
	logic                               duplicate_tags_reg;

	logic                               core_take;
	logic                               sys_take;
	logic                               drv_ready;
	logic                               drv_start;
	logic [3:0]                         drv_code;
	logic                               drv_cls;
	logic                               drv_long;
	logic                               send_fatal;
	logic                               send_snoop;
	logic                               send_iak;

	// Core request to address bus packet
	function automatic port_pkg::addr_req_s encode_req(input port_pkg::core_req_s req);
		port_pkg::addr_req_s pkt;
		pkt.addr      = req.addr;
		pkt.size_log2 = port_pkg::SIZE_LOG2_BLOCK;
		pkt.cls       = port_pkg::CLASS_WRITE;
		pkt.ttype     = port_pkg::interrupt_req;
		unique case (req.cause)
			port_pkg::CAUSE_LOAD_MISS: begin
				pkt.ttype = port_pkg::read_to_share_req;
				pkt.cls   = port_pkg::CLASS_READ;
			end
			port_pkg::CAUSE_IFETCH_MISS: begin
				pkt.ttype = port_pkg::read_to_share_always_req;
				pkt.cls   = port_pkg::CLASS_READ;
			end
			port_pkg::CAUSE_STORE_MISS,
			port_pkg::CAUSE_STORE_HIT_SHARED,
			port_pkg::CAUSE_MERGE_READ: begin
				pkt.ttype = port_pkg::read_to_own_req;
				pkt.cls   = port_pkg::CLASS_READ;
			end
			port_pkg::CAUSE_BLOCK_LOAD: begin
				pkt.ttype = port_pkg::read_to_discard_req;
				pkt.cls   = port_pkg::CLASS_READ;
			end
			port_pkg::CAUSE_DIRTY_VICTIM: begin
				pkt.ttype = port_pkg::writeback_req;
			end
			port_pkg::CAUSE_BLOCK_STORE: begin
				pkt.ttype = port_pkg::write_invalidate_req;
			end
			port_pkg::CAUSE_INTERRUPT: begin
				pkt.ttype = port_pkg::interrupt_req;
			end
			port_pkg::CAUSE_NC_LOAD: begin
				pkt.ttype     = port_pkg::noncached_single_read_req;
				pkt.size_log2 = (req.size_log2 > port_pkg::SIZE_LOG2_MAX_SINGLE)
					? port_pkg::SIZE_LOG2_MAX_SINGLE : req.size_log2;
			end
			port_pkg::CAUSE_NC_BLOCK_READ: begin
				pkt.ttype = port_pkg::noncached_block_read_req;
			end
			port_pkg::CAUSE_NC_BLOCK_WRITE: begin
				pkt.ttype = port_pkg::noncached_block_write_req;
			end
			default: begin
				pkt.ttype = port_pkg::interrupt_req;
			end
		endcase
		return pkt;
	endfunction

	// Coherent system requests that need a tag lookup
	function automatic logic is_coherent(input logic [3:0] ttype);
		return (ttype == port_pkg::sys_invalidate_req)
			|| (ttype == port_pkg::sys_copyback_req)
			|| (ttype == port_pkg::sys_copyback_invalidate_req)
			|| (ttype == port_pkg::sys_copyback_discard_req);
	endfunction

	// Pin inputs pass two flip-flops
	always_ff @(posedge clock_i) begin
		port_id_meta_reg <= port_id_i;
		port_id_reg      <= port_id_meta_reg;
		duplicate_tags_meta_reg   <= duplicate_tags_i;
		duplicate_tags_reg        <= duplicate_tags_meta_reg;
	end

	// One request in flight keeps issue order
	assign core_req_ready_o = !addr_req_valid_reg || addr_grant_i;
	assign core_take        = core_req_valid_i && core_req_ready_o;
	assign addr_req_valid_o = addr_req_valid_reg;
	assign addr_req_o       = addr_req_reg;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			addr_req_valid_reg <= 1'b0;
		end else if (core_take) begin
			addr_req_valid_reg <= 1'b1;
		end else if (addr_grant_i) begin
			addr_req_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			addr_req_reg <= '0;
		end else if (core_take) begin
			addr_req_reg <= encode_req(core_req_i);
		end
	end

	// System request handling
	assign sys_req_ready_o = (snoop_state_reg == SNOOP_IDLE);
	assign sys_take        = sys_req_valid_i && sys_req_ready_o;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			snoop_state_reg <= SNOOP_IDLE;
		end else begin
			unique case (snoop_state_reg)
				SNOOP_IDLE: begin
					if (sys_take) begin
						if (is_coherent(sys_req_i.ttype)) begin
							snoop_state_reg <= SNOOP_LOOKUP;
						end else if ((sys_req_i.ttype == port_pkg::sys_noncached_read_req)
							|| (sys_req_i.ttype == port_pkg::sys_noncached_block_read)) begin
							snoop_state_reg <= SNOOP_REPLY;
						end
					end
				end
				SNOOP_LOOKUP: begin
					if (lookup_done_i) begin
						snoop_state_reg <= SNOOP_REPLY;
					end
				end
				SNOOP_REPLY: begin
					if (send_snoop) begin
						snoop_state_reg <= SNOOP_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sys_req_reg <= '0;
		end else if (sys_take) begin
			sys_req_reg <= sys_req_i;
		end
	end

	// Reply code chosen for the current system request
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			snoop_code_reg <= port_pkg::reply_coherent_ack;
		end else if (sys_take) begin
			if (sys_req_i.ttype == port_pkg::sys_noncached_read_req) begin
				snoop_code_reg <= port_pkg::reply_read_single_ready;
			end else begin
				snoop_code_reg <= port_pkg::reply_read_error;
			end
		end else if ((snoop_state_reg == SNOOP_LOOKUP) && lookup_done_i) begin
			if (!lookup_result_i.hit && !duplicate_tags_reg) begin
				snoop_code_reg <= port_pkg::reply_nonexistent_block;
			end else if (lookup_result_i.victim_pending) begin
				snoop_code_reg <= port_pkg::reply_dirty_victim_ack;
			end else begin
				snoop_code_reg <= port_pkg::reply_coherent_ack;
			end
		end
	end

	// Tag lookup; copyback-discard leaves the line alone
	assign lookup_valid_o          = (snoop_state_reg == SNOOP_LOOKUP);
	assign lookup_o.addr           = sys_req_reg.addr;
	assign lookup_o.invalidate     = (sys_req_reg.ttype == port_pkg::sys_invalidate_req)
		|| (sys_req_reg.ttype == port_pkg::sys_copyback_invalidate_req);
	assign lookup_o.update_state   = (sys_req_reg.ttype != port_pkg::sys_copyback_discard_req);
	assign lookup_o.flush_sb_check = (sys_req_reg.ttype != port_pkg::sys_copyback_discard_req);

	// Slave read data is the port identifier
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			slave_data_reg <= '0;
		end else if (sys_take && (sys_req_i.ttype == port_pkg::sys_noncached_read_req)) begin
			slave_data_reg <= {{(port_pkg::DATA_W-port_pkg::PORT_ID_W){1'b0}}, port_id_reg};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			slave_data_valid_reg <= 1'b0;
		end else if (sys_take) begin
			slave_data_valid_reg <= (sys_req_i.ttype == port_pkg::sys_noncached_read_req);
		end
	end

	assign slave_data_o       = slave_data_reg;
	assign slave_data_valid_o = slave_data_valid_reg;

	// Interrupt delivery and acknowledge
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			int_pending_reg <= 1'b0;
		end else if (sys_take && (sys_req_i.ttype == port_pkg::sys_interrupt_req)) begin
			int_pending_reg <= 1'b1;
		end else if (int_serviced_i) begin
			int_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			int_cls_reg <= 1'b0;
		end else if (sys_take && (sys_req_i.ttype == port_pkg::sys_interrupt_req)) begin
			int_cls_reg <= sys_req_i.cls;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			int_ack_pending_reg <= 1'b0;
		end else if (int_pending_reg && int_serviced_i) begin
			int_ack_pending_reg <= 1'b1;
		end else if (send_iak) begin
			int_ack_pending_reg <= 1'b0;
		end
	end

	assign int_delivered_o = int_pending_reg;

	// Parity errors: set wins over the clear by sending
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fatal_pending_reg <= 1'b0;
		end else if (addr_parity_err_i || tag_parity_err_i) begin
			fatal_pending_reg <= 1'b1;
		end else if (send_fatal) begin
			fatal_pending_reg <= 1'b0;
		end
	end

	// Priority: fatal, system reply, interrupt ack
	assign send_fatal = drv_ready && fatal_pending_reg;
	assign send_snoop = drv_ready && !fatal_pending_reg && (snoop_state_reg == SNOOP_REPLY);
	assign send_iak   = drv_ready && !fatal_pending_reg && (snoop_state_reg != SNOOP_REPLY)
		&& int_ack_pending_reg;
	assign drv_start  = send_fatal || send_snoop || send_iak;

	always_comb begin
		drv_code = port_pkg::reply_interrupt_ack;
		drv_cls  = int_cls_reg;
		drv_long = 1'b1;
		if (fatal_pending_reg) begin
			drv_code = port_pkg::reply_fatal_error;
			drv_cls  = 1'b0;
			drv_long = 1'b0;
		end else if (snoop_state_reg == SNOOP_REPLY) begin
			drv_code = snoop_code_reg;
			drv_cls  = sys_req_reg.cls;
		end
	end

	reply_driver u_reply_driver (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.start_i   (drv_start),
		.code_i    (drv_code),
		.cls_i     (drv_cls),
		.long_i    (drv_long),
		.ready_o   (drv_ready),
		.p_reply_o (p_reply_o)
	);

endmodule

`default_nettype wire

// ==== verilog/port_pkg.sv ====
// Types and constants of the port logic
package port_pkg;

	localparam int ADDR_W    = 36;
	localparam int DATA_W    = 128;
	localparam int PORT_ID_W = 5;

	// Origin of a core request
	typedef enum logic [3:0] {
		CAUSE_LOAD_MISS,
		CAUSE_IFETCH_MISS,
		CAUSE_STORE_MISS,
		CAUSE_STORE_HIT_SHARED,
		CAUSE_MERGE_READ,
		CAUSE_BLOCK_LOAD,
		CAUSE_DIRTY_VICTIM,
		CAUSE_BLOCK_STORE,
		CAUSE_INTERRUPT,
		CAUSE_NC_LOAD,
		CAUSE_NC_BLOCK_READ,
		CAUSE_NC_BLOCK_WRITE
	} cause_e;

	// Transaction type field of outgoing requests
	localparam logic [3:0] read_to_share_req          = 4'h0;
	localparam logic [3:0] read_to_share_always_req   = 4'h1;
	localparam logic [3:0] read_to_own_req            = 4'h2;
	localparam logic [3:0] read_to_discard_req        = 4'h3;
	localparam logic [3:0] writeback_req              = 4'h4;
	localparam logic [3:0] write_invalidate_req       = 4'h5;
	localparam logic [3:0] interrupt_req              = 4'h6;
	localparam logic [3:0] noncached_single_read_req  = 4'h7;
	localparam logic [3:0] noncached_block_read_req   = 4'h8;
	localparam logic [3:0] noncached_block_write_req  = 4'h9;

	// Transaction type field of incoming system requests
	localparam logic [3:0] sys_invalidate_req          = 4'h0;
	localparam logic [3:0] sys_copyback_req            = 4'h1;
	localparam logic [3:0] sys_copyback_invalidate_req = 4'h2;
	localparam logic [3:0] sys_copyback_discard_req    = 4'h3;
	localparam logic [3:0] sys_interrupt_req           = 4'h6;
	localparam logic [3:0] sys_noncached_read_req      = 4'h7;
	localparam logic [3:0] sys_noncached_block_read    = 4'h8;

	// Ordering classes
	localparam logic CLASS_READ  = 1'b0;
	localparam logic CLASS_WRITE = 1'b1;

	// Transfer sizes as log2 of bytes
	localparam logic [2:0] SIZE_LOG2_MAX_SINGLE = 3'h4;
	localparam logic [2:0] SIZE_LOG2_BLOCK      = 3'h6;

	// Reply type codes
	localparam logic [4:0] REPLY_IDLE                = 5'h00;
	localparam logic [3:0] reply_fatal_error         = 4'h4;
	localparam logic [3:0] reply_read_error          = 4'h5;
	localparam logic [3:0] reply_nonexistent_block   = 4'h7;
	localparam logic [3:0] reply_read_single_ready   = 4'h8;
	localparam logic [3:0] reply_coherent_ack        = 4'hA;
	localparam logic [3:0] reply_interrupt_ack       = 4'hC;
	localparam logic [3:0] reply_dirty_victim_ack    = 4'hD;

	// Reply lengths in clock cycles
	localparam logic [1:0] REPLY_SHORT_CYCLES = 2'h1;
	localparam logic [1:0] REPLY_LONG_CYCLES  = 2'h2;

	typedef struct packed {
		cause_e              cause;
		logic [ADDR_W-1:0]   addr;
		logic [2:0]          size_log2;
	} core_req_s;

	typedef struct packed {
		logic [3:0]          ttype;
		logic                cls;
		logic [ADDR_W-1:0]   addr;
		logic [2:0]          size_log2;
	} addr_req_s;

	typedef struct packed {
		logic [3:0]          ttype;
		logic                cls;
		logic [ADDR_W-1:0]   addr;
	} sys_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0]   addr;
		logic                invalidate;
		logic                update_state;
		logic                flush_sb_check;
	} lookup_req_s;

	typedef struct packed {
		logic                hit;
		logic                victim_pending;
	} lookup_res_s;

endpackage

// ==== verilog/reply_driver.sv ====
// Five-bit reply pin driver
`timescale 1ns/10ps
`default_nettype none

module reply_driver (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,
	input  wire logic [3:0] code_i,
	input  wire logic       cls_i,
	input  wire logic       long_i,
	output logic            ready_o,
	output logic [4:0]      p_reply_o
);

	logic [1:0] remain_reg;
	logic [4:0] reply_reg;

	// Next reply may start in the last cycle
	assign ready_o   = (remain_reg <= port_pkg::REPLY_SHORT_CYCLES);
	assign p_reply_o = reply_reg;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			remain_reg <= 2'h0;
		end else if (start_i && ready_o) begin
			remain_reg <= long_i ? port_pkg::REPLY_LONG_CYCLES
				: port_pkg::REPLY_SHORT_CYCLES;
		end else if (remain_reg != 2'h0) begin
			remain_reg <= remain_reg - 2'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reply_reg <= port_pkg::REPLY_IDLE;
		end else if (start_i && ready_o) begin
			reply_reg <= {long_i ? cls_i : 1'b0, code_i};
		end else if (remain_reg <= port_pkg::REPLY_SHORT_CYCLES) begin
			reply_reg <= port_pkg::REPLY_IDLE;
		end
	end

endmodule

`default_nettype wire

// ==== sim/port_txn_sva.sv ====
// Assertions on the port logic
`timescale 1ns/10ps
`default_nettype none
module port_txn_sva (
	input wire logic                        clock_i,
	input wire logic                        rst_i,
	input wire logic                        addr_req_valid_o,
	input wire port_pkg::addr_req_s         addr_req_o,
	input wire logic                        addr_grant_i,
	input wire logic                        sys_req_valid_i,
	input wire port_pkg::sys_req_s          sys_req_i,
	input wire logic                        sys_req_ready_o,
	input wire logic                        lookup_valid_o,
	input wire port_pkg::lookup_req_s       lookup_o,
	input wire logic                        lookup_done_i,
	input wire port_pkg::lookup_res_s       lookup_result_i,
	input wire logic                        int_delivered_o,
	input wire logic                        int_serviced_i,
	input wire logic [port_pkg::DATA_W-1:0] slave_data_o,
	input wire logic                        slave_data_valid_o,
	input wire logic [4:0]                  port_id_i,
	input wire logic                        duplicate_tags_i,
	input wire logic                        addr_parity_err_i,
	input wire logic                        tag_parity_err_i,
	input wire logic [4:0]                  p_reply_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic       taken;
	logic [3:0] snoop_exp_reg;
	assign taken = sys_req_valid_i && sys_req_ready_o;
	// Owed snoop reply
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			snoop_exp_reg <= 4'h0;
		end else if (lookup_valid_o && lookup_done_i) begin
			snoop_exp_reg <= (!lookup_result_i.hit && !duplicate_tags_i) ? 4'h7 :
				(lookup_result_i.victim_pending ? 4'hD : 4'hA);
		end
	end
	a_idle_class: assert property (p_reply_o[3:0] == 4'h0 |-> !p_reply_o[4])
		else $error("idle class set");
	a_codes_legal: assert property (p_reply_o[3:0] inside {4'h0, 4'h4, 4'h5, 4'h7,
		4'h8, 4'hA, 4'hC, 4'hD}) else $error("bad reply code");
	a_long_two: assert property ((p_reply_o[3:0] inside {4'h5, 4'h7, 4'h8, 4'hA, 4'hC,
		4'hD} && p_reply_o != $past(p_reply_o)) |=> p_reply_o == $past(p_reply_o))
		else $error("reply too short");
	a_fatal_sent: assert property ((addr_parity_err_i || tag_parity_err_i)
		|-> ##[1:6] p_reply_o[3:0] == 4'h4) else $error("no fatal reply");
	a_class_map: assert property (addr_req_valid_o |->
		addr_req_o.cls == (addr_req_o.ttype >= 4'h4)) else $error("request in wrong class");
	a_req_hold: assert property (addr_req_valid_o && !addr_grant_i |=>
		addr_req_valid_o && $stable(addr_req_o)) else $error("request moved");
	a_single_size: assert property (addr_req_valid_o && addr_req_o.ttype == 4'h7 |->
		addr_req_o.size_log2 <= 3'h4) else $error("single read too long");
	a_block_size: assert property (addr_req_valid_o && addr_req_o.ttype inside {4'h8, 4'h9}
		|-> addr_req_o.size_log2 == 3'h6) else $error("block size wrong");
	a_slave_read: assert property (taken && sys_req_i.ttype == 4'h7 |=> slave_data_valid_o
		&& slave_data_o[4:0] == port_id_i ##1 p_reply_o == {$past(sys_req_i.cls, 2), 4'h8}
		##1 p_reply_o[3:0] == 4'h8) else $error("slave read wrong");
	a_read_error: assert property (taken && sys_req_i.ttype == 4'h8 |=>
		!slave_data_valid_o ##1 p_reply_o[3:0] == 4'h5) else $error("block read not refused");
	a_discard_keep: assert property (taken && sys_req_i.ttype == 4'h3 |=> lookup_valid_o
		&& !lookup_o.update_state && !lookup_o.flush_sb_check)
		else $error("discard touches state");
	a_snoop_reply: assert property (lookup_valid_o && lookup_done_i |->
		##[2:4] p_reply_o[3:0] == snoop_exp_reg) else $error("snoop reply code wrong");
	a_int_ack: assert property (int_delivered_o && int_serviced_i |->
		##[1:8] p_reply_o[3:0] == 4'hC) else $error("no interrupt ack");
endmodule
`default_nettype wire

// ==== sim/sys_ctrl_model.sv ====
// System side model: grants and tag lookups
`timescale 1ns/10ps
`default_nettype none
module sys_ctrl_model (
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic                  slow_i,
	input  wire logic                  req_valid_i,
	output logic                       grant_o,
	input  wire logic                  lookup_valid_i,
	input  wire port_pkg::lookup_res_s result_i,
	output logic                       done_o,
	output var port_pkg::lookup_res_s  result_o
);
	logic [1:0] wait_reg;
	logic [1:0] lk_reg;
	// One grant at a time keeps classes ordered
	always_ff @(posedge clock_i) begin
		if (rst_i || !req_valid_i || grant_o) begin
			wait_reg <= 2'h0;
			grant_o  <= 1'b0;
		end else begin
			wait_reg <= wait_reg + 2'h1;
			grant_o  <= !slow_i || wait_reg == 2'h2;
		end
	end
	always_ff @(posedge clock_i) begin
		if (rst_i || !lookup_valid_i || done_o) begin
			lk_reg <= 2'h0;
			done_o <= 1'b0;
		end else begin
			lk_reg <= lk_reg + 2'h1;
			done_o <= lk_reg == 2'h1;
		end
	end
	// Junk outside done
	assign result_o = done_o ? result_i : ~result_i;
endmodule
`default_nettype wire

// ==== sim/processor_port_transaction_logic_test.sv ====
// Bench for the port transaction logic
`timescale 1ns/10ps
`default_nettype none
module processor_port_transaction_logic_test;
	logic                        clock_i, rst_i, core_req_valid_i, core_req_ready_o;
	logic                        addr_req_valid_o, addr_grant_i, sys_req_valid_i;
	logic                        sys_req_ready_o, lookup_valid_o, lookup_done_i;
	logic                        int_delivered_o, int_serviced_i, slave_data_valid_o;
	logic                        duplicate_tags_i, addr_parity_err_i, tag_parity_err_i, slow;
	logic                        in_long, last_cls;
	logic [4:0]                  port_id_i, p_reply_o, rep_exp;
	logic [port_pkg::DATA_W-1:0] slave_data_o;
	logic [63:0]                 rnd;
	port_pkg::core_req_s         core_req_i;
	port_pkg::addr_req_s         addr_req_o, req_exp;
	port_pkg::sys_req_s          sys_req_i;
	port_pkg::lookup_req_s       lookup_o;
	port_pkg::lookup_res_s       lookup_result_i, tag_res;
	logic [4:0]                  rep_q [$];
	port_pkg::addr_req_s         req_q [$];
	logic [3:0]                  t_map [12] = '{0, 1, 2, 2, 2, 3, 4, 5, 6, 7, 8, 9};
	int                          seed, error_cnt, total_checks;

	processor_port_transaction_logic u_processor_port_transaction_logic (.clock_i, .rst_i,
		.core_req_valid_i, .core_req_i, .core_req_ready_o, .addr_req_valid_o, .addr_req_o,
		.addr_grant_i, .sys_req_valid_i, .sys_req_i, .sys_req_ready_o, .lookup_valid_o,
		.lookup_o, .lookup_done_i, .lookup_result_i, .int_delivered_o, .int_serviced_i,
		.slave_data_o, .slave_data_valid_o, .port_id_i, .duplicate_tags_i,
		.addr_parity_err_i, .tag_parity_err_i, .p_reply_o);
	sys_ctrl_model u_sys_ctrl_model (.clock_i, .rst_i, .slow_i(slow),
		.req_valid_i(addr_req_valid_o), .grant_o(addr_grant_i), .lookup_valid_i(lookup_valid_o),
		.result_i(tag_res), .done_o(lookup_done_i), .result_o(lookup_result_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// 0 core rdy, 1 sys rdy, 2 int, 3 queues empty
	task automatic wait_sig(input int sel);
		int n;
		n = 0;
		while (!(sel == 0 ? core_req_ready_o === 1'b1 : sel == 1 ? sys_req_ready_o === 1'b1 :
			sel == 2 ? int_delivered_o === 1'b1 : rep_q.size() + req_q.size() == 0)) begin
			@(posedge clock_i);
			#1;
			n++;
			if (n > 80) begin
				error_cnt++;
				give_verdict();
			end
		end
	endtask

	// Valid stays high for back-to-back calls
	task automatic core_send(input port_pkg::cause_e c, input logic [3:0] t);
		rnd = {$random(seed), $random(seed)};
		core_req_valid_i = 1'b1;
		core_req_i = {c, rnd[35:0], rnd[38:36]};
		wait_sig(0);
		req_q.push_back({t, t >= 4'h4, rnd[35:0], c == port_pkg::CAUSE_NC_LOAD ?
			(rnd[38:36] > 3'h4 ? 3'h4 : rnd[38:36]) : 3'h6});
		@(posedge clock_i);
		#1;
	endtask

	task automatic sys_send(input logic [3:0] t, input logic [3:0] code);
		rnd = {$random(seed), $random(seed)};
		wait_sig(1);
		last_cls = rnd[36];
		sys_req_valid_i = 1'b1;
		sys_req_i = {t, last_cls, rnd[35:0]};
		if (code != 4'h0) rep_q.push_back({last_cls, code});
		@(posedge clock_i);
		#1;
		sys_req_valid_i = 1'b0;
	endtask

	always @(posedge clock_i) begin
		if (addr_req_valid_o === 1'b1 && addr_grant_i === 1'b1) begin
			if (req_q.size() == 0) check("unexpected request", 64'h0, 64'h1);
			else begin
				req_exp = req_q.pop_front();
				check("request", req_exp[43:3], addr_req_o[43:3]);
				if (req_exp.ttype >= 4'h7) check("size", req_exp.size_log2, addr_req_o.size_log2);
			end
		end
	end

	always @(posedge clock_i) begin
		if (rst_i === 1'b0 && p_reply_o !== 5'h00 && !in_long) begin
			if (rep_q.size() == 0) check("unexpected reply", 64'h0, p_reply_o);
			else begin
				rep_exp = rep_q.pop_front();
				if (rep_exp[3:0] == 4'h4) check("fatal", 4'h4, p_reply_o[3:0]);
				else check("reply", rep_exp, p_reply_o);
			end
			in_long = p_reply_o[3:0] != 4'h4;
		end else in_long = 1'b0;
	end

	initial begin
		seed = 61154;
		error_cnt = 0;
		total_checks = 0;
		in_long = 1'b0;
		rst_i = 1'b1;
		{core_req_valid_i, sys_req_valid_i, int_serviced_i, slow} = 4'h0;
		{duplicate_tags_i, addr_parity_err_i, tag_parity_err_i} = 3'h0;
		core_req_i = '0;
		sys_req_i = '0;
		tag_res = '0;
		rnd = {$random(seed), $random(seed)};
		port_id_i = rnd[4:0];
		repeat (8) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		check("idle reply", 5'h00, p_reply_o);
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			for (int i = 0; i < 12; i++) begin
				core_send(port_pkg::cause_e'(i), t_map[i]);
			end
			core_req_valid_i = 1'b0;
			wait_sig(3);
		end
		sys_send(4'h7, 4'h8);
		check("slave data", {1'b1, port_id_i}, {slave_data_valid_o, slave_data_o[4:0]});
		sys_send(4'h8, 4'h5);
		check("no slave data", 1'b0, slave_data_valid_o);
		for (int i = 0; i < 32; i++) begin
			duplicate_tags_i = i[4];
			tag_res = {i[2], i[3]};
			repeat (3) @(posedge clock_i);
			#1;
			sys_send(i[1:0], (!i[2] && !i[4]) ? 4'h7 : (i[3] ? 4'hD : 4'hA));
			check("lookup", {rnd[35:0], !i[0]}, {lookup_o.addr, lookup_o.invalidate});
			wait_sig(3);
		end
		sys_send(4'h6, 4'h0);
		wait_sig(2);
		rep_q.push_back({last_cls, 4'hC});
		int_serviced_i = 1'b1;
		@(posedge clock_i);
		#1;
		int_serviced_i = 1'b0;
		wait_sig(3);
		check("interrupt cleared", 1'b0, int_delivered_o);
		for (int i = 0; i < 2; i++) begin
			rep_q.push_back(5'h04);
			{addr_parity_err_i, tag_parity_err_i} = i[0] ? 2'h1 : 2'h2;
			@(posedge clock_i);
			#1;
			{addr_parity_err_i, tag_parity_err_i} = 2'h0;
			wait_sig(3);
		end
		repeat (4) @(posedge clock_i);
		give_verdict();
	end
endmodule

bind processor_port_transaction_logic port_txn_sva u_port_txn_sva (.clock_i, .rst_i,
	.addr_req_valid_o, .addr_req_o, .addr_grant_i, .sys_req_valid_i, .sys_req_i,
	.sys_req_ready_o, .lookup_valid_o, .lookup_o, .lookup_done_i, .lookup_result_i,
	.int_delivered_o, .int_serviced_i, .slave_data_o, .slave_data_valid_o, .port_id_i,
	.duplicate_tags_i, .addr_parity_err_i, .tag_parity_err_i, .p_reply_o);
`default_nettype wire
